/* adgc_config_regs.sv */
`timescale 1ns/1ps
module adgc_config_regs
    import adgc_pkg::*;
#(
    parameter int CHANNELS = 8
) (
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  sys_rst,
    // Register access port from the serial front end
    input  wire logic [7:0]            reg_addr,
    input  wire logic                  reg_wr,
    input  wire logic [7:0]            reg_wdata,
    input  wire logic                  reg_rd,
    output logic      [7:0]            reg_rdata,
    output logic                       reg_rvalid,
    // Converter core
    output logic                       conversion_trigger,
    output logic                       cal_start,
    input  wire logic                  cal_done,
    input  wire logic                  avg_busy,
    input  wire logic                  avg_ready,
    input  wire logic                  brownout_event,
    input  wire logic                  conv_valid,
    input  wire logic [11:0]           conv_data,
    input  wire logic [3:0]            conv_channel_id,
    output logic      [15:0]           out_data,
    output logic                       out_valid,
    output logic                       out_has_tag,
    // Timing and averaging settings
    output logic      [2:0]            averaging_ratio,
    output logic      [7:0]            avg_samples,
    output logic                       oscillator_choice,
    output logic      [3:0]            speed_divider,
    // Channel configuration, after the force override
    output logic      [CHANNELS-1:0]   channel_is_gpio,
    output logic      [CHANNELS-1:0]   gpio_is_output
);

    logic                  force_analog_all;
    logic                  cal_active;
    logic                  fixed_pattern_out;
    logic [1:0]            tag_mode;
    logic [CHANNELS-1:0]   channel_function_map;
    logic [CHANNELS-1:0]   digital_pin_direction_map;
    logic                  averaging_complete_flag;
    logic                  brownout_flag;
    adgc_swrst_type        swrst_state;
    logic                  swrst_apply;

    // Writes are not taken while a soft reset is being applied
    logic wr_ok;
    assign wr_ok       = reg_wr && (swrst_state == SWRST_IDLE);
    assign swrst_apply = (swrst_state == SWRST_BUSY);

    // One strobe per register; unmapped addresses raise none
    logic wr_status;
    logic wr_general;
    logic wr_format;
    logic wr_averaging;
    logic wr_timing;
    logic wr_func_map;
    logic wr_dir_map;
    assign wr_status    = wr_ok && (reg_addr == ADDR_SYSTEM_STATUS);
    assign wr_general   = wr_ok && (reg_addr == ADDR_GENERAL_CONTROL);
    assign wr_format    = wr_ok && (reg_addr == ADDR_OUTPUT_FORMAT);
    assign wr_averaging = wr_ok && (reg_addr == ADDR_AVERAGING);
    assign wr_timing    = wr_ok && (reg_addr == ADDR_TIMING_MODE);
    assign wr_func_map  = wr_ok && (reg_addr == ADDR_CHANNEL_FUNC);
    assign wr_dir_map   = wr_ok && (reg_addr == ADDR_PIN_DIRECTION);

    // Soft reset: one cycle to clear, bit reads one until done
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            swrst_state <= SWRST_IDLE;
        end else begin
            case (swrst_state)
                SWRST_IDLE: begin
                    if (wr_ok && reg_addr == ADDR_GENERAL_CONTROL
                        && reg_wdata[GEN_SWRST_BIT]) begin
                        swrst_state <= SWRST_BUSY;
                    end
                end
                SWRST_BUSY: begin
                    swrst_state <= SWRST_IDLE;
                end
                default: begin
                    swrst_state <= SWRST_IDLE;
                end
            endcase
        end
    end

    // Conversion trigger is a pulse only, never stored
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            conversion_trigger <= 1'b0;
        end else begin
            conversion_trigger <= wr_ok && reg_addr == ADDR_GENERAL_CONTROL
                                  && reg_wdata[GEN_TRIGGER_BIT];
        end
    end

    // General control stored fields
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            force_analog_all <= RST_CONFIG[GEN_FORCE_BIT];
            cal_active       <= RST_CONFIG[GEN_CAL_BIT];
            cal_start        <= 1'b0;
        end else begin
            cal_start <= 1'b0;
            if (swrst_apply) begin
                force_analog_all <= RST_CONFIG[GEN_FORCE_BIT];
                cal_active       <= RST_CONFIG[GEN_CAL_BIT];
            end else begin
                if (wr_general) begin
                    force_analog_all <= reg_wdata[GEN_FORCE_BIT];
                end
                // A finish is never lost to a same-cycle write
                if (cal_active && cal_done) begin
                    cal_active <= 1'b0;
                end else if (wr_general && reg_wdata[GEN_CAL_BIT] && !cal_active) begin
                    cal_active <= 1'b1;
                    cal_start  <= 1'b1;
                end
            end
        end
    end

    // Output format; only defined fields are stored
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            fixed_pattern_out <= RST_CONFIG[FMT_FIXED_BIT];
            tag_mode          <= RST_CONFIG[FMT_TAG_HI:FMT_TAG_LO];
        end else if (swrst_apply) begin
            fixed_pattern_out <= RST_CONFIG[FMT_FIXED_BIT];
            tag_mode          <= RST_CONFIG[FMT_TAG_HI:FMT_TAG_LO];
        end else if (wr_format) begin
            fixed_pattern_out <= reg_wdata[FMT_FIXED_BIT];
            tag_mode          <= reg_wdata[FMT_TAG_HI:FMT_TAG_LO];
        end
    end

    // Averaging ratio
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            averaging_ratio <= RST_CONFIG[AVG_HI:AVG_LO];
        end else if (swrst_apply) begin
            averaging_ratio <= RST_CONFIG[AVG_HI:AVG_LO];
        end else if (wr_averaging) begin
            averaging_ratio <= reg_wdata[AVG_HI:AVG_LO];
        end
    end

    // Oscillator and sampling speed
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            oscillator_choice <= RST_CONFIG[OSC_CHOICE_BIT];
            speed_divider     <= RST_CONFIG[DIV_HI:DIV_LO];
        end else if (swrst_apply) begin
            oscillator_choice <= RST_CONFIG[OSC_CHOICE_BIT];
            speed_divider     <= RST_CONFIG[DIV_HI:DIV_LO];
        end else if (wr_timing) begin
            oscillator_choice <= reg_wdata[OSC_CHOICE_BIT];
            speed_divider     <= reg_wdata[DIV_HI:DIV_LO];
        end
    end

    // Channel function map
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            channel_function_map <= RST_CONFIG[CHANNELS-1:0];
        end else if (swrst_apply) begin
            channel_function_map <= RST_CONFIG[CHANNELS-1:0];
        end else if (wr_func_map) begin
            channel_function_map <= reg_wdata[CHANNELS-1:0];
        end
    end

    // Pin direction map
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            digital_pin_direction_map <= RST_CONFIG[CHANNELS-1:0];
        end else if (swrst_apply) begin
            digital_pin_direction_map <= RST_CONFIG[CHANNELS-1:0];
        end else if (wr_dir_map) begin
            digital_pin_direction_map <= reg_wdata[CHANNELS-1:0];
        end
    end

    // Averaging flag: a hardware set beats a same-cycle clear
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            averaging_complete_flag <= 1'b0;
        end else if (avg_ready) begin
            averaging_complete_flag <= 1'b1;
        end else if (avg_busy || swrst_apply) begin
            averaging_complete_flag <= 1'b0;
        end else if (wr_status && reg_wdata[STAT_AVG_DONE_BIT]) begin
            averaging_complete_flag <= 1'b0;
        end
    end

    // Brown-out flag survives a soft reset
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            brownout_flag <= RST_BROWNOUT;
        end else if (brownout_event) begin
            brownout_flag <= 1'b1;
        end else if (wr_status && reg_wdata[STAT_BROWNOUT_BIT]) begin
            brownout_flag <= 1'b0;
        end
    end

    // Read mux; trigger never reads back, unmapped reads give zero
    logic [7:0] next_rdata;
    always_comb begin
        next_rdata = 8'h00;
        if (reg_addr == ADDR_SYSTEM_STATUS) begin
            next_rdata[STAT_ALWAYS_ONE_BIT] = 1'b1;
            next_rdata[STAT_AVG_DONE_BIT]   = averaging_complete_flag;
            next_rdata[STAT_BROWNOUT_BIT]   = brownout_flag;
        end else if (reg_addr == ADDR_GENERAL_CONTROL) begin
            next_rdata[GEN_FORCE_BIT] = force_analog_all;
            next_rdata[GEN_CAL_BIT]   = cal_active;
            next_rdata[GEN_SWRST_BIT] = swrst_apply;
        end else if (reg_addr == ADDR_OUTPUT_FORMAT) begin
            next_rdata[FMT_FIXED_BIT]         = fixed_pattern_out;
            next_rdata[FMT_TAG_HI:FMT_TAG_LO] = tag_mode;
        end else if (reg_addr == ADDR_AVERAGING) begin
            next_rdata[AVG_HI:AVG_LO] = averaging_ratio;
        end else if (reg_addr == ADDR_TIMING_MODE) begin
            next_rdata[OSC_CHOICE_BIT] = oscillator_choice;
            next_rdata[DIV_HI:DIV_LO]  = speed_divider;
        end else if (reg_addr == ADDR_CHANNEL_FUNC) begin
            next_rdata[CHANNELS-1:0] = channel_function_map;
        end else if (reg_addr == ADDR_PIN_DIRECTION) begin
            next_rdata[CHANNELS-1:0] = digital_pin_direction_map;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= next_rdata;
            end
        end
    end

    // Output data formatting; tag rides in the low nibble
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            out_data    <= 16'h0000;
            out_valid   <= 1'b0;
            out_has_tag <= 1'b0;
        end else begin
            out_valid <= conv_valid;
            if (conv_valid) begin
                if (fixed_pattern_out) begin
                    out_data    <= {FIXED_PATTERN_CODE, 4'h0};
                    out_has_tag <= 1'b0;
                end else if (tag_mode == TAG_CHANNEL_ID) begin
                    out_data    <= {conv_data, conv_channel_id};
                    out_has_tag <= 1'b1;
                end else begin
                    out_data    <= {conv_data, 4'h0};
                    out_has_tag <= 1'b0;
                end
            end
        end
    end

    // Samples per result: code 0 means a single sample
    always_comb begin
        avg_samples = 8'h01 << averaging_ratio;
    end

    // Force override wins over both maps
    always_comb begin
        channel_is_gpio = force_analog_all ? '0 : channel_function_map;
        gpio_is_output  = channel_is_gpio & digital_pin_direction_map;
    end

endmodule // adgc_config_regs

/* adgc_config_regs_monitor.sv */
`timescale 1ns/1ps
module adgc_config_regs_monitor
    import adgc_pkg::*;
#(parameter int CHANNELS = 8) (
    // Clock, reset and register port
    input wire logic                ref_clk,
    input wire logic                sys_rst,
    input wire logic [7:0]          reg_addr,
    input wire logic                reg_wr,
    input wire logic [7:0]          reg_wdata,
    input wire logic                reg_rd,
    input wire logic [7:0]          reg_rdata,
    input wire logic                reg_rvalid,
    // Converter side and settings
    input wire logic                conversion_trigger,
    input wire logic [15:0]         out_data,
    input wire logic                out_valid,
    input wire logic                out_has_tag,
    input wire logic [2:0]          averaging_ratio,
    input wire logic [7:0]          avg_samples,
    input wire logic                oscillator_choice,
    input wire logic [3:0]          speed_divider,
    input wire logic [CHANNELS-1:0] channel_is_gpio,
    input wire logic [CHANNELS-1:0] gpio_is_output
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // Mirrors the one-cycle soft reset window in which writes are dropped
    logic rst_busy;
    wire  ok_wr    = reg_wr && !rst_busy;
    wire  gen_wr   = ok_wr && reg_addr == ADDR_GENERAL_CONTROL;
    wire  trig_req = gen_wr && reg_wdata[GEN_TRIGGER_BIT];
    wire  force_wr = gen_wr && reg_wdata[GEN_FORCE_BIT];
    wire  avg_wr   = ok_wr && reg_addr == ADDR_AVERAGING;
    wire  tm_wr    = ok_wr && reg_addr == ADDR_TIMING_MODE;
    wire  rsvd_rd  = reg_rd && (reg_addr == ADDR_GENERAL_CONTROL
                                || reg_addr == ADDR_AVERAGING);
    wire [4:0] timing_now = {oscillator_choice, speed_divider};
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst)
            rst_busy <= 1'b0;
        else
            rst_busy <= gen_wr && reg_wdata[GEN_SWRST_BIT];
    end
    sequence s_swrst_req;
        gen_wr && reg_wdata[GEN_SWRST_BIT];
    endsequence
    sequence s_cleared;
        averaging_ratio == 3'h0 && speed_divider == 4'h0 && channel_is_gpio == '0;
    endsequence
    sequence s_rd_single;
        reg_rd ##1 !reg_rd;
    endsequence
    a_trig_pulse: assert property (trig_req |=> conversion_trigger)
        else $error("trigger pulse missing");
    a_rd_answer: assert property (s_rd_single |-> reg_rvalid ##1 $stable(reg_rdata))
        else $error("read answer wrong");
    a_rsvd_zero: assert property (rsvd_rd |=> reg_rdata[7:3] == 5'h0)
        else $error("reserved bits not zero");
    a_avg_write: assert property (avg_wr |=> averaging_ratio == 3'($past(reg_wdata)))
        else $error("averaging field not written");
    a_timing_write: assert property (tm_wr |=> timing_now == 5'($past(reg_wdata)))
        else $error("timing fields not written");
    a_avg_samples: assert property ($onehot(avg_samples) && avg_samples[averaging_ratio])
        else $error("sample count wrong");
    a_gpio_subset: assert property ((gpio_is_output & ~channel_is_gpio) == '0)
        else $error("output set on analog channel");
    a_force_analog: assert property (force_wr |=> channel_is_gpio == '0)
        else $error("force left a GPIO channel");
    a_tag_absent: assert property (out_valid && !out_has_tag |-> out_data[3:0] == 4'h0)
        else $error("untagged data has nibble");
    a_swrst_clears: assert property (s_swrst_req |-> ##2 s_cleared)
        else $error("soft reset left settings");
endmodule // adgc_config_regs_monitor

bind adgc_config_regs adgc_config_regs_monitor #(.CHANNELS(CHANNELS))
    i_adgc_config_regs_monitor (.*);

/* adgc_config_regs_test.sv */
`timescale 1ns/1ps
module adgc_config_regs_test;
    import adgc_pkg::*;
    typedef struct { logic [7:0] a, d, r; } adgc_row_type;
    logic        ref_clk, sys_rst, cal_done, avg_busy, avg_ready, brownout_event, conv_valid;
    logic        reg_wr, reg_rd, reg_rvalid, conversion_trigger, cal_start, out_valid;
    logic        out_has_tag, oscillator_choice;
    logic [11:0] conv_data;
    logic [3:0]  conv_channel_id, speed_divider;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, avg_samples, channel_is_gpio, gpio_is_output;
    logic [15:0] out_data;
    logic [2:0]  averaging_ratio;
    int          failures, checks;
    adgc_row_type rows [6] = '{'{ADDR_OUTPUT_FORMAT, 8'hff, 8'hb0},
        '{ADDR_AVERAGING, 8'hff, 8'h07}, '{ADDR_TIMING_MODE, 8'hff, 8'h1f},
        '{ADDR_CHANNEL_FUNC, 8'ha5, 8'ha5}, '{ADDR_PIN_DIRECTION, 8'h3c, 8'h3c},
        '{8'h06, 8'hff, 8'h00}};
    adgc_config_regs i_adgc_config_regs (.*);
    adgc_host_model i_adgc_host_model (.*);
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        checks++;
        if (seen !== want) begin
            failures++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, want);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] want);
        logic [7:0] d;
        i_adgc_host_model.rd(a, d);
        check(16'(d), 16'(want));
    endtask
    task automatic conv(input logic [15:0] want, input logic tag);
        @(posedge ref_clk);
        conv_valid <= 1'b1;
        conv_data <= 12'h123;
        @(posedge ref_clk);
        conv_valid <= 1'b0;
        conv_data <= 12'hedc;
        @(negedge ref_clk);
        check(out_data, want);
        check(16'(out_valid), 16'h0001);
        check(16'(out_has_tag), 16'(tag));
    endtask
    task automatic wrap_up;
        $display("Checks %0d, failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge ref_clk);
        failures++;
        wrap_up();
    end
    initial begin
        {sys_rst, cal_done, avg_busy, avg_ready, brownout_event, conv_valid} = 6'b100000;
        conv_data = 12'h000;
        conv_channel_id = 4'h5;
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd_chk(ADDR_SYSTEM_STATUS, 8'h81);
        foreach (rows[i]) begin
            rd_chk(rows[i].a, 8'h00);
            i_adgc_host_model.wr(rows[i].a, rows[i].d);
            rd_chk(rows[i].a, rows[i].r);
        end
        check(16'({averaging_ratio, oscillator_choice, speed_divider}), 16'h00ff);
        check({channel_is_gpio, gpio_is_output}, 16'ha524);
        // Fixed pattern wins over tag mode 3; then tag mode 1 tags and tag mode 0 does not
        conv(16'ha5a0, 1'b0);
        i_adgc_host_model.wr(ADDR_OUTPUT_FORMAT, 8'h10);
        conv(16'h1235, 1'b1);
        i_adgc_host_model.wr(ADDR_OUTPUT_FORMAT, 8'h00);
        conv(16'h1230, 1'b0);
        for (int k = 0; k < 8; k++) begin
            i_adgc_host_model.wr(ADDR_AVERAGING, 8'(k));
            @(negedge ref_clk);
            check(16'(avg_samples), 16'(1 << k));
        end
        i_adgc_host_model.wr(ADDR_GENERAL_CONTROL, 8'h0c);
        @(negedge ref_clk);
        check({7'h0, conversion_trigger, channel_is_gpio | gpio_is_output}, 16'h0100);
        rd_chk(ADDR_GENERAL_CONTROL, 8'h04);
        i_adgc_host_model.wr(ADDR_GENERAL_CONTROL, 8'h06);
        @(negedge ref_clk);
        check(16'(cal_start), 16'h0001);
        rd_chk(ADDR_GENERAL_CONTROL, 8'h06);
        cal_done <= 1'b1;
        i_adgc_host_model.settle(GEN_CAL_BIT);
        cal_done <= 1'b0;
        rd_chk(ADDR_GENERAL_CONTROL, 8'h04);
        @(posedge ref_clk);
        avg_ready <= 1'b1;
        @(posedge ref_clk);
        avg_ready <= 1'b0;
        rd_chk(ADDR_SYSTEM_STATUS, 8'h89);
        i_adgc_host_model.wr(ADDR_SYSTEM_STATUS, 8'h09);
        rd_chk(ADDR_SYSTEM_STATUS, 8'h80);
        {brownout_event, avg_ready} <= 2'b11;
        @(posedge ref_clk);
        {brownout_event, avg_ready, avg_busy} <= 3'b001;
        @(posedge ref_clk);
        avg_busy <= 1'b0;
        rd_chk(ADDR_SYSTEM_STATUS, 8'h81);
        i_adgc_host_model.wr(ADDR_GENERAL_CONTROL, 8'h01);
        i_adgc_host_model.settle(GEN_SWRST_BIT);
        rd_chk(ADDR_GENERAL_CONTROL, 8'h00);
        rd_chk(ADDR_CHANNEL_FUNC, 8'h00);
        check(16'({averaging_ratio, speed_divider, gpio_is_output}), 16'h0000);
        rd_chk(ADDR_SYSTEM_STATUS, 8'h81);
        wrap_up();
    end
endmodule // adgc_config_regs_test

/* adgc_host_model.sv */
`timescale 1ns/1ps
module adgc_host_model
    import adgc_pkg::*;
(
    // Clock
    input  wire logic       ref_clk,
    // Register port
    output logic      [7:0] reg_addr,
    output logic            reg_wr,
    output logic      [7:0] reg_wdata,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rvalid
);
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end
    // Freed data shows the inverse so a stale copy is never mistaken for data
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
        d = reg_rvalid ? reg_rdata : 8'hxx;
    endtask
    task automatic settle(input int bit_pos);
        logic [7:0] d;
        repeat (20) begin
            rd(ADDR_GENERAL_CONTROL, d);
            if (!d[bit_pos]) break;
        end
    endtask
endmodule // adgc_host_model

/* adgc_pkg.sv */
package adgc_pkg;

    // Register addresses
    localparam logic [7:0] ADDR_SYSTEM_STATUS   = 8'h00;
    localparam logic [7:0] ADDR_GENERAL_CONTROL = 8'h01;
    localparam logic [7:0] ADDR_OUTPUT_FORMAT   = 8'h02;
    localparam logic [7:0] ADDR_AVERAGING       = 8'h03;
    localparam logic [7:0] ADDR_TIMING_MODE     = 8'h04;
    localparam logic [7:0] ADDR_CHANNEL_FUNC    = 8'h05;
    localparam logic [7:0] ADDR_PIN_DIRECTION   = 8'h07;

    // Reset values
    localparam logic [7:0] RST_CONFIG           = 8'h00;
    localparam logic       RST_BROWNOUT         = 1'b1;

    // Status register fields
    localparam int         STAT_ALWAYS_ONE_BIT  = 7;
    localparam int         STAT_AVG_DONE_BIT    = 3;
    localparam int         STAT_BROWNOUT_BIT    = 0;

    // General control fields
    localparam int         GEN_TRIGGER_BIT      = 3;
    localparam int         GEN_FORCE_BIT        = 2;
    localparam int         GEN_CAL_BIT          = 1;
    localparam int         GEN_SWRST_BIT        = 0;

    // Output format fields
    localparam int         FMT_FIXED_BIT        = 7;
    localparam int         FMT_TAG_HI           = 5;
    localparam int         FMT_TAG_LO           = 4;
    localparam logic [1:0] TAG_NONE             = 2'h0;
    localparam logic [1:0] TAG_CHANNEL_ID       = 2'h1;
    localparam logic [11:0] FIXED_PATTERN_CODE  = 12'ha5a;

    // Averaging and timing fields
    localparam int         AVG_HI               = 2;
    localparam int         AVG_LO               = 0;
    localparam int         OSC_CHOICE_BIT       = 4;
    localparam int         DIV_HI               = 3;
    localparam int         DIV_LO               = 0;

    // Software reset state machine
    typedef enum logic [1:0] {
        SWRST_IDLE = 2'b01,
        SWRST_BUSY = 2'b10
    } adgc_swrst_type;

endpackage
